// >>> hdl/lcdc_display_mem.v
// display memory with shadow copy, per common row, for the segment lcd core
`timescale 1ns/10ps

module lcdc_display_mem #(
  parameter ENTRIES = 8,
  parameter WIDTH = 20
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus side
  input wire wr_en,
  input wire [2:0] wr_idx,
  input wire [WIDTH-1:0] wr_data,
  input wire wipe,
  input wire [2:0] rd_idx,
  output wire [WIDTH-1:0] rd_data,
  // display side
  input wire reload,
  input wire [1:0] com_sel,
  output wire [2*WIDTH-1:0] row_out
);

reg [WIDTH-1:0] mem [0:ENTRIES-1];
reg [WIDTH-1:0] shadow [0:ENTRIES-1];

genvar i;
generate
  for (i = 0; i < ENTRIES; i = i + 1) begin : g_entry
    always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        mem[i] <= {WIDTH{1'b0}};
        shadow[i] <= {WIDTH{1'b0}};
      end else begin
        if (wipe) begin
          mem[i] <= {WIDTH{1'b0}};
        end else if (wr_en && wr_idx == i) begin
          mem[i] <= wr_data;
        end
        if (reload) begin
          shadow[i] <= mem[i];
        end
      end
    end
  end
endgenerate

assign rd_data = mem[rd_idx];
assign row_out = {shadow[{com_sel, 1'b1}], shadow[{com_sel, 1'b0}]};

endmodule

// >>> hdl/lcdc_frame_timer.v
// prescaler, clock divider and frame slot counter of the segment lcd core
`timescale 1ns/10ps
`include "lcdc_regs.vh"

module lcdc_frame_timer (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire run,
  input wire tap_sel,
  input wire [2:0] div_ratio,
  input wire third_duty,
  // timing
  output reg [2:0] phase_reg,
  output reg frame_start_reg
);

reg [3:0] ripple_reg;
reg [2:0] div_cnt_reg;
reg started_reg;
wire tap_tick;
wire ps_tick;
wire [2:0] last_slot;

assign tap_tick = tap_sel ? (ripple_reg == `LCDC_TAP16_LAST) :
                  (ripple_reg[2:0] == `LCDC_TAP8_LAST);
assign ps_tick = tap_tick & (div_cnt_reg == div_ratio);
assign last_slot = third_duty ? `LCDC_K6_LAST : `LCDC_K8_LAST;

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    ripple_reg <= 4'h0;
    div_cnt_reg <= 3'h0;
    phase_reg <= 3'h0;
    started_reg <= 1'b0;
    frame_start_reg <= 1'b0;
  end else if (!run) begin
    ripple_reg <= 4'h0;
    div_cnt_reg <= 3'h0;
    phase_reg <= 3'h0;
    started_reg <= 1'b0;
    frame_start_reg <= 1'b0;
  end else begin
    ripple_reg <= ripple_reg + 4'h1;
    started_reg <= 1'b1;
    frame_start_reg <= 1'b0;
    if (tap_tick) begin
      div_cnt_reg <= ps_tick ? 3'h0 : div_cnt_reg + 3'h1;
    end
    if (!started_reg) begin
      frame_start_reg <= 1'b1;
    end else if (ps_tick) begin
      if (phase_reg >= last_slot) begin
        phase_reg <= 3'h0;
        frame_start_reg <= 1'b1;
      end else begin
        phase_reg <= phase_reg + 3'h1;
      end
    end
  end
end

endmodule

// >>> hdl/lcdc_regs.vh
// register map, field positions, reset values and timing codes of the segment lcd core
`ifndef LCDC_REGS_VH
`define LCDC_REGS_VH

// byte offsets
`define LCDC_MAIN_OFS 12'h000
`define LCDC_CLK_OFS 12'h004
`define LCDC_SEGCNT_OFS 12'h008
`define LCDC_MEM_OFS 12'h040
`define LCDC_MEM_MASK 12'hfe0

// reset values
`define LCDC_MAIN_RST 8'h00
`define LCDC_CLK_RST 8'h00
`define LCDC_SEGCNT_RST 6'h00

// main control fields
`define LCDC_EN_BIT 7
`define LCDC_EXTERNAL_BIAS_SELECT_BIT 6
`define LCDC_FREEZE_BIT 5
`define LCDC_CREV_BIT 4
`define LCDC_SREV_BIT 3
`define LCDC_WIPE_BIT 2
`define LCDC_VIS_BIT 1
`define LCDC_BLANK_BIT 0

// clock and duty fields
`define LCDC_TAP_BIT 7
`define LCDC_DIV_HI 6
`define LCDC_DIV_LO 4
`define LCDC_LPW_BIT 3
`define LCDC_DUTY_HI 1
`define LCDC_DUTY_LO 0
`define LCDC_CLK_WMASK 8'hfb

// duty codes
`define LCDC_DUTY_QUARTER 2'b00
`define LCDC_DUTY_STATIC 2'b01
`define LCDC_DUTY_HALF 2'b10
`define LCDC_DUTY_THIRD 2'b11

// frame slots minus one, and the six-slot half point: k = 8 or 6
`define LCDC_K8_LAST 3'd7
`define LCDC_K6_LAST 3'd5
`define LCDC_K6_HALF 3'd3

// ripple counter tap points: divide by 8 or 16
`define LCDC_TAP8_LAST 3'h7
`define LCDC_TAP16_LAST 4'hf

// terminal counts
`define LCDC_NUM_SEG 40
`define LCDC_GPIO_FIRST 24

// drive level codes, fractions of the lcd supply
`define LCDC_LV_GND 2'd0
`define LCDC_LV_THIRD 2'd1
`define LCDC_LV_TWO 2'd2
`define LCDC_LV_TOP 2'd3

`endif

// >>> hdl/lcdc_top.v
// segment lcd control and frame timing core with ahb-lite register slave
// ------------------------------------------------------------
// Summary of operation
// - enable runs driver; clear grounds outputs immediately
// - external bias turns intermediate buffers off
// - freeze holds shadow; reload at frame start
// - common reversal mirrors all four commons
// - segment reversal mirrors all forty terminals
// - wipe zeroes memory, blanks one frame, self-clears
// - visible clear shows all segments off
// - blank grounds all terminals after frame
// - tap bit selects divide by 8 or 16
// - divider field divides by value plus one
// - frame is k slots, k 8 or 6
// - low-power wave change applies next frame
// - duty field selects four, one, two, three commons
// - unused commons held at ground
// - segment count sets drivers; undriven ones of top sixteen go gpio
// ------------------------------------------------------------
`timescale 1ns/10ps
`include "lcdc_regs.vh"

module lcdc_top (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // segment terminals, two level bits each
  output reg [79:0] seg_level,
  output reg [39:0] seg_drive_en,
  output reg [39:0] seg_gpio_sel,
  // common terminals, two level bits each
  output reg [7:0] com_level,
  // analog controls and timing
  output reg bias_buffer_en,
  output wire frame_start
);

// ------------------------------------------------------------
// bus slave
// ------------------------------------------------------------
reg [7:0] main_reg;
reg [7:0] clk_reg;
reg [5:0] segcnt_reg;
reg wr_pend_reg;
reg rd_pend_reg;
reg hit_reg;
reg [9:0] addr_reg;
reg [31:0] rd_next;
wire take;
wire [11:0] wbyte;
wire wr_now;
wire mem_hit;
wire [19:0] mem_rd;

assign take = hsel & hready & htrans[1];
assign wbyte = {addr_reg, 2'b00};
assign wr_now = wr_pend_reg & hit_reg;
assign mem_hit = (wbyte & `LCDC_MEM_MASK) == `LCDC_MEM_OFS;

// reads insert one wait state so a read right after a write sees it
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    wr_pend_reg <= 1'b0;
    rd_pend_reg <= 1'b0;
    hit_reg <= 1'b0;
    addr_reg <= 10'h000;
    hreadyout <= 1'b1;
    hresp <= 1'b0;
    hrdata <= 32'h00000000;
  end else begin
    hresp <= 1'b0;
    if (rd_pend_reg) begin
      hrdata <= rd_next;
      hreadyout <= 1'b1;
      rd_pend_reg <= 1'b0;
    end else if (take) begin
      wr_pend_reg <= hwrite;
      rd_pend_reg <= ~hwrite;
      hreadyout <= hwrite;
      hit_reg <= ~|haddr[31:12];
      addr_reg <= haddr[11:2];
    end else if (hready) begin
      wr_pend_reg <= 1'b0;
    end
  end
end

always @* begin
  rd_next = 32'h00000000;
  if (hit_reg) begin
    if (mem_hit) begin
      rd_next = {12'h000, mem_rd};
    end else begin
      case (wbyte)
        `LCDC_MAIN_OFS: rd_next = {24'h000000, main_reg};
        `LCDC_CLK_OFS: rd_next = {24'h000000, clk_reg};
        `LCDC_SEGCNT_OFS: rd_next = {26'h0, segcnt_reg};
        default: rd_next = 32'h00000000;
      endcase
    end
  end
end

// ------------------------------------------------------------
// control registers
// ------------------------------------------------------------
wire en;
wire wipe;
wire freeze;
wire frame_go;
reg blank_act_reg;
reg wipe_pend_reg;
reg lpw_act_reg;
reg [1:0] duty_act_reg;
reg parity_reg;

assign en = main_reg[`LCDC_EN_BIT];
assign wipe = main_reg[`LCDC_WIPE_BIT];
assign freeze = main_reg[`LCDC_FREEZE_BIT];
assign frame_go = frame_start;

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    main_reg <= `LCDC_MAIN_RST;
    clk_reg <= `LCDC_CLK_RST;
    segcnt_reg <= `LCDC_SEGCNT_RST;
  end else begin
    if (wr_now && !mem_hit && wbyte == `LCDC_MAIN_OFS) begin
      main_reg <= hwdata[7:0];
    end else if (wipe) begin
      main_reg[`LCDC_WIPE_BIT] <= 1'b0;
    end
    if (wr_now && !mem_hit && wbyte == `LCDC_CLK_OFS) begin
      clk_reg <= hwdata[7:0] & `LCDC_CLK_WMASK;
    end
    if (wr_now && !mem_hit && wbyte == `LCDC_SEGCNT_OFS) begin
      segcnt_reg <= hwdata[5:0];
    end
  end
end

// frame-bound state
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    blank_act_reg <= 1'b0;
    wipe_pend_reg <= 1'b0;
    lpw_act_reg <= 1'b0;
    duty_act_reg <= `LCDC_DUTY_QUARTER;
    parity_reg <= 1'b0;
  end else if (!en) begin
    blank_act_reg <= 1'b0;
    wipe_pend_reg <= wipe_pend_reg | wipe;
    lpw_act_reg <= clk_reg[`LCDC_LPW_BIT];
    duty_act_reg <= clk_reg[`LCDC_DUTY_HI:`LCDC_DUTY_LO];
    parity_reg <= 1'b0;
  end else begin
    if (frame_go) begin
      blank_act_reg <= main_reg[`LCDC_BLANK_BIT] | wipe_pend_reg;
      parity_reg <= ~parity_reg;
      lpw_act_reg <= clk_reg[`LCDC_LPW_BIT];
      duty_act_reg <= clk_reg[`LCDC_DUTY_HI:`LCDC_DUTY_LO];
    end
    // new wipe wins over the frame clear
    if (wipe) begin
      wipe_pend_reg <= 1'b1;
    end else if (frame_go) begin
      wipe_pend_reg <= 1'b0;
    end
  end
end

// ------------------------------------------------------------
// timing and memory
// ------------------------------------------------------------
wire [2:0] phase;
wire third;
wire [39:0] row;
reg [1:0] cur_com;
reg [1:0] com_last;
reg pol;

assign third = duty_act_reg == `LCDC_DUTY_THIRD;

lcdc_frame_timer u_timer (
  .hclk(hclk),
  .hresetn(hresetn),
  .run(en),
  .tap_sel(clk_reg[`LCDC_TAP_BIT]),
  .div_ratio(clk_reg[`LCDC_DIV_HI:`LCDC_DIV_LO]),
  .third_duty(third),
  .phase_reg(phase),
  .frame_start_reg(frame_start)
);

// frozen shadow holds; a wipe still reloads
lcdc_display_mem #(
  .ENTRIES(8),
  .WIDTH(20)
) u_mem (
  .hclk(hclk),
  .hresetn(hresetn),
  .wr_en(wr_now & mem_hit),
  .wr_idx(addr_reg[2:0]),
  .wr_data(hwdata[19:0]),
  .wipe(wipe),
  .rd_idx(addr_reg[2:0]),
  .rd_data(mem_rd),
  .reload(frame_go & (~freeze | wipe_pend_reg)),
  .com_sel(cur_com),
  .row_out(row)
);

// duty decode to active common and count
always @* begin
  cur_com = 2'd0;
  com_last = 2'd0;
  case (duty_act_reg)
    `LCDC_DUTY_QUARTER: begin
      cur_com = phase[1:0];
      com_last = 2'd3;
    end
    `LCDC_DUTY_HALF: begin
      cur_com = {1'b0, phase[0]};
      com_last = 2'd1;
    end
    `LCDC_DUTY_THIRD: begin
      cur_com = (phase >= `LCDC_K6_HALF) ? phase[1:0] - 2'd3 : phase[1:0];
      com_last = 2'd2;
    end
    default: begin
      cur_com = 2'd0;
      com_last = 2'd0;
    end
  endcase
end

// low-power waves hold one polarity per frame
always @* begin
  if (lpw_act_reg) begin
    pol = parity_reg;
  end else if (third) begin
    pol = phase >= `LCDC_K6_HALF;
  end else begin
    pol = phase[2];
  end
end

// ------------------------------------------------------------
// terminal waveforms
// ------------------------------------------------------------
wire is_static;
wire visible;
wire quiet;
wire [79:0] seg_lv;
wire [39:0] seg_drv;
wire [39:0] seg_gp;
wire [7:0] com_lv;

assign is_static = duty_act_reg == `LCDC_DUTY_STATIC;
assign visible = main_reg[`LCDC_VIS_BIT];
assign quiet = ~en | blank_act_reg;

genvar t;
generate
  for (t = 0; t < `LCDC_NUM_SEG; t = t + 1) begin : g_seg
    wire on;
    wire [1:0] lv;
    assign on = row[t] & visible;
    assign lv = is_static ? ((on ^ pol) ? `LCDC_LV_TOP : `LCDC_LV_GND) :
                on ? (pol ? `LCDC_LV_GND : `LCDC_LV_TOP) :
                (pol ? `LCDC_LV_TWO : `LCDC_LV_THIRD);
    assign seg_drv[t] = en & ({1'b0, segcnt_reg} > t);
    assign seg_gp[t] = (t >= `LCDC_GPIO_FIRST) & ~seg_drv[t];
    assign seg_lv[2*t+1:2*t] = (quiet | ~seg_drv[t]) ? `LCDC_LV_GND : lv;
  end
endgenerate

genvar c;
generate
  for (c = 0; c < 4; c = c + 1) begin : g_com
    wire used;
    wire [1:0] lv;
    assign used = com_last >= c;
    assign lv = (is_static || cur_com == c) ?
                (pol ? `LCDC_LV_TOP : `LCDC_LV_GND) :
                (pol ? `LCDC_LV_THIRD : `LCDC_LV_TWO);
    assign com_lv[2*c+1:2*c] = (quiet | ~used) ? `LCDC_LV_GND : lv;
  end
endgenerate

// ------------------------------------------------------------
// output registers and bus reversal
// ------------------------------------------------------------
integer p;
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    seg_level <= 80'h0;
    seg_drive_en <= 40'h0;
    seg_gpio_sel <= 40'h0;
    com_level <= 8'h00;
    bias_buffer_en <= 1'b0;
  end else begin
    bias_buffer_en <= en & ~main_reg[`LCDC_EXTERNAL_BIAS_SELECT_BIT];
    // mirror whole segment bus, even disabled
    for (p = 0; p < `LCDC_NUM_SEG; p = p + 1) begin
      if (main_reg[`LCDC_SREV_BIT]) begin
        seg_level[2*p +: 2] <= seg_lv[2*(39-p) +: 2];
        seg_drive_en[p] <= seg_drv[39-p];
        seg_gpio_sel[p] <= seg_gp[39-p];
      end else begin
        seg_level[2*p +: 2] <= seg_lv[2*p +: 2];
        seg_drive_en[p] <= seg_drv[p];
        seg_gpio_sel[p] <= seg_gp[p];
      end
    end
    for (p = 0; p < 4; p = p + 1) begin
      if (main_reg[`LCDC_CREV_BIT]) begin
        com_level[2*p +: 2] <= com_lv[2*(3-p) +: 2];
      end else begin
        com_level[2*p +: 2] <= com_lv[2*p +: 2];
      end
    end
  end
end

endmodule

// >>> tb/lcdc_chk_sva.sv
// port assertions for the segment lcd core
`timescale 1ns/10ps
module lcdc_chk (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // terminals
  input wire [79:0] seg_level,
  input wire [39:0] seg_drive_en,
  input wire [39:0] seg_gpio_sel,
  input wire [7:0] com_level,
  input wire bias_buffer_en,
  input wire frame_start
);
  wire take = hsel & hready & htrans[1];
  reg ap_wr_reg;
  reg ap_main_reg;
  reg main_wr_reg;
  reg [7:0] main_val_reg;
  // main control value as software last wrote it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg <= 1'b0;
      ap_main_reg <= 1'b0;
      main_wr_reg <= 1'b0;
      main_val_reg <= 8'h00;
    end else begin
      if (hready) begin
        ap_wr_reg <= take & hwrite;
        ap_main_reg <= haddr == 32'h0;
      end
      main_wr_reg <= hready & ap_wr_reg & ap_main_reg;
      if (hready & ap_wr_reg & ap_main_reg) begin
        main_val_reg <= hwdata[7:0];
      end
    end
  end
  // ------
  // assertions
  // ------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (take & !hwrite |=> s_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take & hwrite |=> hreadyout)
    else $error("write wait state seen");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside a read");
  a_off_ground: assert property (main_wr_reg && !main_val_reg[7] |-> ##[0:2]
    (seg_level == 80'h0 && com_level == 8'h0 && seg_drive_en == 40'h0))
    else $error("outputs not grounded after disable");
  a_bias_ctrl: assert property (main_wr_reg |-> ##[0:2]
    (bias_buffer_en == (main_val_reg[7] & !main_val_reg[6])))
    else $error("bias buffer enable wrong");
  a_frame_pulse: assert property (frame_start |=> !frame_start)
    else $error("frame strobe longer than one cycle");
  a_pin_owner: assert property (((seg_drive_en & seg_gpio_sel) |
    (seg_gpio_sel & 40'h0000ff0000)) == 40'h0)
    else $error("segment pin ownership wrong");
  a_blank_frame: assert property (main_val_reg[0] && main_val_reg[7] &&
    !main_wr_reg && frame_start |-> ##[1:3] (seg_level == 80'h0 && com_level == 8'h0))
    else $error("terminals not grounded while blanked");
endmodule

bind lcdc_top lcdc_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .seg_level(seg_level),
  .seg_drive_en(seg_drive_en), .seg_gpio_sel(seg_gpio_sel), .com_level(com_level),
  .bias_buffer_en(bias_buffer_en), .frame_start(frame_start));

// >>> tb/lcdc_glass.sv
// passive glass model: pixels on the first physical common
`timescale 1ns/10ps
module lcdc_glass (
  // drive levels
  input wire [79:0] seg_level,
  input wire [7:0] com_level,
  // dark pixels
  output logic [39:0] lit
);
  // a pixel darkens when segment and common codes are complements: ground against top, or third against two
  always_comb begin
    for (int p = 0; p < 40; p++) lit[p] = (seg_level[2*p +: 2] ^ com_level[1:0]) == 2'b11;
  end
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the segment lcd core
`timescale 1ns/10ps
`include "lcdc_regs.vh"
module tb_top;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, bias_buffer_en, frame_start;
  wire [79:0] seg_level;
  wire [39:0] seg_drive_en, seg_gpio_sel, lit;
  wire [7:0] com_level;
  localparam logic [31:0] main_a = {20'h0, `LCDC_MAIN_OFS};
  localparam logic [31:0] clk_a = {20'h0, `LCDC_CLK_OFS};
  localparam logic [31:0] seg_a = {20'h0, `LCDC_SEGCNT_OFS};
  localparam logic [31:0] mem_a = {20'h0, `LCDC_MEM_OFS};
  logic [7:0] clk_tab [8] = '{8'h00, 8'h80, 8'h70, 8'hf3, 8'h21, 8'h12, 8'h01, 8'h0b};
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int n, k, ncom;
  logic [31:0] rd;
  logic [7:0] cv;
  logic [3:0] seen, m, lvs;

  lcdc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .seg_level(seg_level),
    .seg_drive_en(seg_drive_en), .seg_gpio_sel(seg_gpio_sel), .com_level(com_level),
    .bias_buffer_en(bias_buffer_en), .frame_start(frame_start));
  lcdc_glass u_glass (.seg_level(seg_level), .com_level(com_level), .lit(lit));

  always #25 hclk = ~hclk;
  // a hang ends the run as a failure
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      $display("FAIL at %0t: timeout", $time);
      num_errors++;
      conclude();
    end
  end
  // ------
  // tasks
  // ------
  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic frames(input int cnt);
    repeat (cnt) begin
      @(posedge hclk);
      while (frame_start !== 1'b1) @(posedge hclk);
    end
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(main_a, 32'h0);
    rchk(clk_a, 32'h0);
    rchk(seg_a, 32'h0);
    wr(32'h100, 32'hffffffff);
    rchk(32'h100, 32'h0);
    wr(clk_a, 32'hfb);
    rchk(clk_a, 32'hfb);
    wr(seg_a, 32'h14);
    // both taps, dividers 0, 1, 2 and 7, each duty setting, with both bus reversals
    for (int i = 0; i < 8; i++) begin
      cv = clk_tab[i];
      wr(clk_a, {24'h0, cv});
      wr(main_a, (i == 6) ? 32'h92 : (i == 7) ? 32'h8a : 32'h82);
      frames(2);
      seen = 4'h0;
      lvs = 4'h0;
      n = 0;
      do begin
        @(posedge hclk);
        n++;
        for (int c = 0; c < 4; c++) seen[c] = seen[c] | (com_level[2*c +: 2] != 2'd0);
        // the first sample still shows the previous frame's polarity
        if (n > 1) lvs[com_level[1:0]] = 1'b1;
      end while (frame_start !== 1'b1);
      // low-power frames keep one polarity on the first common throughout
      check(lvs == 4'h5 || lvs == 4'ha, cv[3]);
      k = (cv[1:0] == 2'b11) ? 6 : 8;
      check(n, k * (cv[7] ? 16 : 8) * (cv[6:4] + 1));
      ncom = (cv[1:0] == 2'b00) ? 4 : cv[1:0];
      m = 4'hf >> (4 - ncom);
      check(seen, (i == 6) ? {m[0], m[1], m[2], m[3]} : m);
      check(seg_drive_en, (i == 7) ? 40'hfffff00000 : 40'h00000fffff);
      check(seg_gpio_sel, (i == 7) ? 40'h000000ffff : 40'hffff000000);
      check(bias_buffer_en, 1'b1);
    end
    // static display: data, visibility, freeze, blank and wipe
    wr(seg_a, 32'h28);
    wr(mem_a, 32'h1);
    wr(clk_a, 32'h01);
    wr(main_a, 32'hc2);
    frames(2);
    check(bias_buffer_en, 1'b0);
    check(lit, 40'h1);
    wr(main_a, 32'h80);
    frames(2);
    check(lit, 40'h0);
    wr(main_a, 32'ha2);
    wr(mem_a, 32'h2);
    frames(2);
    check(lit, 40'h1);
    rchk(mem_a, 32'h2);
    wr(main_a, 32'h82);
    frames(2);
    check(lit, 40'h2);
    wr(main_a, 32'h83);
    frames(2);
    check(seg_level, 80'h0);
    check(com_level, 8'h0);
    rchk(mem_a, 32'h2);
    wr(main_a, 32'h86);
    frames(1);
    repeat (3) @(posedge hclk);
    check(com_level, 8'h0);
    rchk(mem_a, 32'h0);
    rchk(main_a, 32'h82);
    rchk(clk_a, 32'h01);
    wr(main_a, 32'h0);
    repeat (3) @(posedge hclk);
    check(seg_level, 80'h0);
    check(com_level, 8'h0);
    check(seg_gpio_sel, 40'hffff000000);
    conclude();
  end
endmodule
